/* hdl/rcf_top.sv */
// Purpose: Combine reset sources, stretch release, record reset cause
// Assumes: aclk 200 MHz; sources from analog monitors and watchdog
// Notes:   Pin reset also forces the output asynchronously via a gate
`timescale 1ns/1ps
// Overview of operation
// - Watchdog expiry makes an internal reset pulse of exactly one clock.
// - Delay count starts as the watchdog pulse ends; reset held until timeout.
// - Low reset pin asserts reset asynchronously, without any clock.
// - After pin returns high, delay count runs before release.
// - Supply rising past power-on threshold starts the delay count.
// - Supply falling below threshold reasserts reset immediately.
// - Enabled brown-out asserts reset at once; release after delay timeout.
// - Bit 4 set by scan reset; cleared by power-on or software zero.
// - Bit 3 set by watchdog reset; cleared by power-on or software zero.
// - Bit 2 set by brown-out reset; cleared by power-on or software zero.
// - Bit 1 set by pin reset; cleared by power-on or software zero.
// - Bit 0 set by power-on; cleared only by software zero.
// - Legacy mode shows only pin and power-on flags.
// - Bandgap on when brown-out enabled, comparator select, or converter on.
// - Reset held while the scan reset register holds one.
// - Delay length chosen by the clock source fuses.
module rcf_top (
   input  wire logic            aclk,                 // System clock
   input  wire logic            aresetn,              // Sync reset, active low
   input  wire rcf_pkg::rcf_src_t src_i,              // Raw reset sources
   input  wire logic            brownout_enable_fuse, // Brown-out detector enabled
   input  wire logic            legacy_mode,          // Compatibility mode strap
   input  wire logic [3:0]      clock_source_fuses,   // Selects delay length
   input  wire logic [31:0]     s_axi_awaddr,         // Write address
   input  wire logic            s_axi_awvalid,        // Write address valid
   output logic                 s_axi_awready,        // Write address ready
   input  wire logic [31:0]     s_axi_wdata,          // Write data
   input  wire logic [3:0]      s_axi_wstrb,          // Write strobes
   input  wire logic            s_axi_wvalid,         // Write data valid
   output logic                 s_axi_wready,         // Write data ready
   output logic [1:0]           s_axi_bresp,          // Write response
   output logic                 s_axi_bvalid,         // Write response valid
   input  wire logic            s_axi_bready,         // Write response ready
   input  wire logic [31:0]     s_axi_araddr,         // Read address
   input  wire logic            s_axi_arvalid,        // Read address valid
   output logic                 s_axi_arready,        // Read address ready
   output logic [31:0]          s_axi_rdata,          // Read data
   output logic [1:0]           s_axi_rresp,          // Read response
   output logic                 s_axi_rvalid,         // Read data valid
   input  wire logic            s_axi_rready,         // Read ready
   output logic                 sys_reset_n,          // Internal reset, active low
   output logic                 bandgap_on,           // Reference power enable
   output logic                 irq                   // Level interrupt
);
   import rcf_pkg::*;

   typedef enum logic [1:0] {ST_HOLD, ST_COUNT, ST_RUN} rcf_state_t;

   rcf_src_t            s1_reg, s2_reg;
   logic                wdt_d_reg;
   logic                wdt_rst_reg;
   rcf_state_t          state_reg;
   logic [DELAY_W-1:0]  cnt_reg;
   logic [DELAY_W-1:0]  tout_cyc;
   logic                hold_src;
   logic                rst_sync_n_reg;
   logic [4:0]          flags_reg;
   logic [4:0]          flag_set;
   logic [4:0]          irq_stat_reg, irq_en_reg;
   logic [1:0]          ctrl_reg;
   logic                aw_hold_reg, w_hold_reg;
   logic [7:0]          aw_addr_reg;
   logic [31:0]         w_data_reg;
   logic                wr_go, wr_ok;
   logic [4:0]          sw_flag_clr, sw_irq_clr;

   // Two-stage synchronisers for all analog/pin sources
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s1_reg <= '0;
         s2_reg <= '0;
      end
      else
      begin
         s1_reg <= src_i;
         s2_reg <= s1_reg;
      end
   end

   // one-cycle watchdog pulse from rising edge of expiry
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wdt_d_reg   <= 1'b0;
         wdt_rst_reg <= 1'b0;
      end
      else
      begin
         wdt_d_reg   <= s2_reg.wdt_pulse;
         wdt_rst_reg <= s2_reg.wdt_pulse & ~wdt_d_reg;
      end
   end

   // delay length from clock source fuses
   always_comb
   begin
      case (clock_source_fuses[1:0])
         2'b00:   tout_cyc = TOUT_MIN_CYC;
         2'b01:   tout_cyc = TOUT_SHORT_CYC;
         default: tout_cyc = TOUT_LONG_CYC;
      endcase
   end

   // level sources and the watchdog pulse that hold reset with no delay stage
   assign hold_src = s2_reg.por_low | s2_reg.pin_low | s2_reg.scan_one
                   | (s2_reg.bod_low & brownout_enable_fuse) | wdt_rst_reg;

   // hold, then count full delay, restart if a source reasserts
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_reg <= ST_HOLD;
         cnt_reg   <= '0;
      end
      else
      begin
         case (state_reg)
            ST_HOLD:
            begin
               cnt_reg <= tout_cyc;
               // count starts when last source drops
               if (!hold_src)
                  state_reg <= ST_COUNT;
            end
            ST_COUNT:
            begin
               if (hold_src)
                  state_reg <= ST_HOLD;
               else if (cnt_reg <= TOUT_MIN_CYC)
                  state_reg <= ST_RUN;
               else
                  cnt_reg <= cnt_reg - TOUT_MIN_CYC;
            end
            ST_RUN:
            begin
               if (hold_src)
                  state_reg <= ST_HOLD;
            end
            default: state_reg <= ST_HOLD;
         endcase
      end
   end

   // Clocked part of the internal reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rst_sync_n_reg <= 1'b0;
      else
         rst_sync_n_reg <= (state_reg == ST_RUN) & ~hold_src;
   end

   // raw pin low forces reset with no clock; glitch filtering is analog
   assign sys_reset_n = rst_sync_n_reg & ~src_i.pin_low;

   // Flag set events, each a source seen active
   assign flag_set[FLAG_POR]  = s2_reg.por_low;
   assign flag_set[FLAG_PIN]  = s2_reg.pin_low;
   assign flag_set[FLAG_BOR]  = s2_reg.bod_low & brownout_enable_fuse;
   assign flag_set[FLAG_WDT]  = wdt_rst_reg;
   assign flag_set[FLAG_SCAN] = s2_reg.scan_one;

   // cause flags; set beats software clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         flags_reg <= 5'h01;
      else if (s2_reg.por_low)
         flags_reg <= 5'h01;
      else
         flags_reg <= (flags_reg & ~sw_flag_clr) | flag_set;
   end

   // Sticky event status, set beats clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_stat_reg <= '0;
         irq_en_reg   <= '0;
         irq          <= 1'b0;
      end
      else
      begin
         irq_stat_reg <= (irq_stat_reg & ~sw_irq_clr) | flag_set;
         if (wr_ok && aw_addr_reg == REG_IRQ_ENABLE && s_axi_wstrb[0])
            irq_en_reg <= w_data_reg[4:0];
         irq <= |(irq_stat_reg & irq_en_reg);
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         bandgap_on <= 1'b0;
      else
         bandgap_on <= brownout_enable_fuse | ctrl_reg[CTRL_CMP_BG] | ctrl_reg[CTRL_ADC];
   end

   // Write channel capture; address and data accepted in either order
   assign wr_go = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
   assign wr_ok = wr_go & s_axi_wstrb[0];
   assign sw_flag_clr = (wr_ok && aw_addr_reg == REG_FLAGS) ? ~w_data_reg[4:0] : 5'h00;
   assign sw_irq_clr  = (wr_ok && aw_addr_reg == REG_IRQ_CLEAR) ? w_data_reg[4:0] : 5'h00;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_reg   <= 1'b0;
         w_hold_reg    <= 1'b0;
         aw_addr_reg   <= '0;
         w_data_reg    <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         ctrl_reg      <= '0;
      end
      else
      begin
         s_axi_awready <= ~aw_hold_reg & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready  <= ~w_hold_reg & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr[7:0];
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
         end
         if (wr_go)
         begin
            aw_hold_reg  <= 1'b0;
            w_hold_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (aw_addr_reg)
               REG_FLAGS, REG_IRQ_ENABLE, REG_IRQ_CLEAR, REG_CTRL: s_axi_bresp <= RESP_OKAY;
               default: s_axi_bresp <= RESP_SLVERR;
            endcase
            if (wr_ok && aw_addr_reg == REG_CTRL)
               ctrl_reg <= w_data_reg[1:0];
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Read channel; one read at a time, answer one cycle after address
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= ZERO32;
         s_axi_rresp   <= RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            s_axi_rdata  <= ZERO32;
            case (s_axi_araddr[7:0])
               // legacy mode hides the newer flags
               REG_FLAGS: s_axi_rdata[4:0] <= legacy_mode ? (flags_reg & LEGACY_MASK)
                                                          : flags_reg;
               REG_IRQ_STATUS: s_axi_rdata[4:0] <= irq_stat_reg;
               REG_IRQ_ENABLE: s_axi_rdata[4:0] <= irq_en_reg;
               REG_IRQ_CLEAR:  s_axi_rdata      <= ZERO32;
               REG_CTRL:       s_axi_rdata[1:0] <= ctrl_reg;
               default:        s_axi_rresp      <= RESP_SLVERR;
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // Assertions
   sequence wdt_edge;
      s2_reg.wdt_pulse && !wdt_d_reg;
   endsequence

   AST_WDT_ONE_CYCLE: assert property (@(posedge aclk) disable iff (!aresetn)
      wdt_edge |=> wdt_rst_reg ##1 !wdt_rst_reg)
      else $error("watchdog reset pulse not one cycle");
   AST_WDT_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
      wdt_rst_reg && !s2_reg.por_low |=> flags_reg[FLAG_WDT])
      else $error("watchdog flag not set");
   AST_POR_CLEARS: assert property (@(posedge aclk) disable iff (!aresetn)
      s2_reg.por_low |=> flags_reg == 5'h01)
      else $error("power-on did not leave only bit 0");
   AST_HOLD_NO_RUN: assert property (@(posedge aclk) disable iff (!aresetn)
      hold_src |=> !rst_sync_n_reg)
      else $error("reset not reasserted at once");
   AST_COUNT_START: assert property (@(posedge aclk) disable iff (!aresetn)
      state_reg == ST_HOLD && !hold_src |=> state_reg == ST_COUNT && cnt_reg == tout_cyc)
      else $error("delay count did not start");
   AST_BOR_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
      flag_set[FLAG_BOR] && !s2_reg.por_low |=> flags_reg[FLAG_BOR])
      else $error("brown-out flag not set");
   AST_PIN_ASYNC: assert property (@(posedge aclk) disable iff (!aresetn)
      src_i.pin_low |-> !sys_reset_n)
      else $error("pin low did not force reset");
   AST_BANDGAP: assert property (@(posedge aclk) disable iff (!aresetn)
      brownout_enable_fuse |=> bandgap_on)
      else $error("bandgap off while brown-out enabled");
   AST_SCAN_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
      s2_reg.scan_one |=> !rst_sync_n_reg && flags_reg[FLAG_SCAN])
      else $error("scan reset not held or flagged");
endmodule : rcf_top

/* hdl/rcf_pkg.sv */
// Purpose: Constants and types for the reset source combiner and cause flags
// Assumes: 200 MHz aclk, AXI4-Lite register access
// Notes:   Delay lengths per clock source fuse setting are plain defaults
package rcf_pkg;
   localparam int             CLK_MHZ          = 200;
   localparam logic [7:0]     REG_FLAGS        = 8'h00;    // Reset cause flags
   localparam logic [7:0]     REG_IRQ_STATUS   = 8'h04;    // Sticky event status
   localparam logic [7:0]     REG_IRQ_ENABLE   = 8'h08;    // Event enable
   localparam logic [7:0]     REG_IRQ_CLEAR    = 8'h0C;    // Write one to clear
   localparam logic [7:0]     REG_CTRL         = 8'h10;    // Comparator/converter bits
   localparam int             FLAG_POR         = 0;
   localparam int             FLAG_PIN         = 1;
   localparam int             FLAG_BOR         = 2;
   localparam int             FLAG_WDT         = 3;
   localparam int             FLAG_SCAN        = 4;
   localparam int             NSRC             = 5;
   localparam logic [4:0]     LEGACY_MASK      = 5'h03;    // Pin and power-up only
   localparam int             CTRL_CMP_BG      = 0;
   localparam int             CTRL_ADC         = 1;
   localparam logic [1:0]     RESP_OKAY        = 2'b00;
   localparam logic [1:0]     RESP_SLVERR      = 2'b10;
   localparam logic [31:0]    ZERO32           = 32'h0000_0000;
   // Delay count for each clock source fuse value, in cycles
   localparam int             DELAY_W          = 24;
   localparam int             TOUT_US_SHORT    = 4;
   localparam int             TOUT_US_LONG     = 65;
   localparam logic [DELAY_W-1:0] TOUT_SHORT_CYC = DELAY_W'(TOUT_US_SHORT * CLK_MHZ);
   localparam logic [DELAY_W-1:0] TOUT_LONG_CYC  = DELAY_W'(TOUT_US_LONG * CLK_MHZ);
   localparam logic [DELAY_W-1:0] TOUT_MIN_CYC   = 24'h00_0001;

   typedef struct packed {
      logic por_low;    // Supply below power-on threshold
      logic pin_low;    // External reset pin low (raw)
      logic bod_low;    // Brown-out detector reports low supply
      logic wdt_pulse;  // Watchdog expiry event
      logic scan_one;   // Scan reset register holds one
   } rcf_src_t;
endpackage : rcf_pkg

/* testbench/rcf_supply_model.sv */
// Purpose: Supply monitors, reset pin, watchdog and scan register
// Assumes: Levels commanded by the bench, applied after each edge
// Notes:   A watchdog request becomes a one-cycle expiry pulse
`timescale 1ns/1ps
module rcf_supply_model (
   input  wire logic              aclk,  // System clock
   input  wire rcf_pkg::rcf_src_t cmd,   // Commanded levels
   output rcf_pkg::rcf_src_t      src_o  // Levels seen by the block
);
   import rcf_pkg::*;
   logic wdt_prev_reg; // Last watchdog request
   initial src_o = '0;
   initial wdt_prev_reg = 1'b0;
   // Registered, so sources never move on the sampling edge
   always @(posedge aclk)
   begin
      wdt_prev_reg <= cmd.wdt_pulse;
      src_o        <= {cmd[4:2], cmd.wdt_pulse & ~wdt_prev_reg, cmd.scan_one};
   end
endmodule : rcf_supply_model

/* testbench/rcf_top_bench.sv */
// Purpose: Self-checking bench for the reset combiner and cause flags
// Assumes: Fuse value 00 gives a one-cycle stretch
// Notes:   Every wait is bounded; a timeout counts as a mismatch
`timescale 1ns/1ps
module rcf_top_bench;
   import rcf_pkg::*;
   localparam logic [4:0] PIN = 5'h08, BOD = 5'h04, WDT = 5'h02, SCN = 5'h01, POR = 5'h10;
   localparam int         BG_WAIT = 70 * CLK_MHZ; // Reference start-up, cycles
   logic        aclk, aresetn, bo_fuse, legacy, awready, wready, bvalid, arready, rvalid;
   logic        awvalid, wvalid, bready, arvalid, rready, sys_reset_n, bandgap_on, irq;
   logic [3:0]  ck_fuses, wstrb;
   logic [1:0]  bresp, rresp;
   logic [31:0] awaddr, wdata, araddr, rdata;
   rcf_src_t    cmd, src;
   int          failures, check_count;

   rcf_supply_model i_model (.aclk(aclk), .cmd(cmd), .src_o(src));
   rcf_top i_dut (.aclk(aclk), .aresetn(aresetn), .src_i(src), .brownout_enable_fuse(bo_fuse),
      .legacy_mode(legacy), .clock_source_fuses(ck_fuses), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .sys_reset_n(sys_reset_n), .bandgap_on(bandgap_on), .irq(irq));

   // 200 MHz clock
   always #2.5 aclk = ~aclk;

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test

   // Compare four-state values and count
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic hang(input string what);
      failures++;
      $display("wrong value %s expected answer seen timeout", what);
      end_of_test();
   endtask : hang

   // Check a level captured at the call; the #1 only delays the compare
   task automatic chk(input string what, input logic got, input logic e);
      #1;
      check(what, {31'h0, e}, {31'h0, got});
   endtask : chk

   // Bounded wait for the internal reset to reach a level
   task automatic wait_rst(input logic lvl, input int lim);
      int n;
      check_count++;
      for (n = 0; n < lim && sys_reset_n !== lvl; n++) @(posedge aclk) #1;
      if (n == lim)
         hang("sys_reset_n");
   endtask : wait_rst

   // Address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge aclk);
      {awaddr, wdata} <= {24'h00_0000, a, d};
      {awvalid, wvalid, bready} <= 3'h7;
      for (n = 0; n < 50 && bvalid !== 1'b1; n++)
      begin
         @(posedge aclk);
         awvalid <= awvalid & ~awready;
         wvalid  <= wvalid & ~wready;
      end
      if (n == 50)
         hang("bvalid");
      bready <= 1'b0;
      check("bresp", {30'h0, er}, {30'h0, bresp});
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      @(posedge aclk);
      araddr <= {24'h00_0000, a};
      {arvalid, rready} <= 2'h3;
      for (n = 0; n < 50 && rvalid !== 1'b1; n++) @(posedge aclk) arvalid <= arvalid & ~arready;
      if (n == 50)
         hang("rvalid");
      rready <= 1'b0;
      check("rresp", {30'h0, er}, {30'h0, rresp});
      if (er == RESP_OKAY)
         check("rdata", ed, rdata);
   endtask : rd

   task automatic pulse(input logic [4:0] s, input int n);
      @(posedge aclk);
      cmd <= s;
      repeat (n) @(posedge aclk);
      cmd <= '0;
   endtask : pulse

   task automatic t_boot();
      wait_rst(1'b1, 40);
      rd(REG_FLAGS, 32'h0000_0001, RESP_OKAY);
      wr(REG_FLAGS, ZERO32, RESP_OKAY);
      wr(REG_IRQ_CLEAR, 32'h0000_001F, RESP_OKAY);
      rd(REG_FLAGS, ZERO32, RESP_OKAY);
      rd(REG_IRQ_CLEAR, ZERO32, RESP_OKAY);
      rd(8'h40, ZERO32, RESP_SLVERR);
      wr(8'h40, 32'h0000_001F, RESP_SLVERR);
      $display("boot test done");
   endtask : t_boot

   // Pin reset must hold reset low, then set the pin flag and irq
   task automatic t_pin();
      wr(REG_IRQ_ENABLE, 32'h0000_0002, RESP_OKAY);
      pulse(PIN, 6);
      chk("async reset", sys_reset_n, 1'b0);
      repeat (2) @(posedge aclk);
      chk("stretch", sys_reset_n, 1'b0);
      wait_rst(1'b1, 40);
      chk("irq raised", irq, 1'b1);
      rd(REG_FLAGS, 32'h0000_0002, RESP_OKAY);
      wr(REG_IRQ_CLEAR, 32'h0000_0002, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("irq cleared", irq, 1'b0);
      wr(REG_FLAGS, ZERO32, RESP_OKAY);
      $display("pin test done");
   endtask : t_pin

   task automatic t_wdt();
      pulse(WDT, 1);
      wait_rst(1'b0, 10);
      wait_rst(1'b1, 40);
      chk("irq masked", irq, 1'b0);
      rd(REG_FLAGS, 32'h0000_0008, RESP_OKAY);
      rd(REG_IRQ_STATUS, 32'h0000_0008, RESP_OKAY);
      wr(REG_FLAGS, ZERO32, RESP_OKAY);
      $display("watchdog test done");
   endtask : t_wdt

   task automatic t_bor();
      pulse(BOD, 4);
      wait_rst(1'b0, 10);
      wait_rst(1'b1, 40);
      rd(REG_FLAGS, 32'h0000_0004, RESP_OKAY);
      wr(REG_FLAGS, ZERO32, RESP_OKAY);
      bo_fuse <= 1'b0;
      pulse(BOD, 8);
      chk("no brown-out", sys_reset_n, 1'b1);
      rd(REG_FLAGS, ZERO32, RESP_OKAY);
      $display("brown-out test done");
   endtask : t_bor

   // Scan reset held long, then legacy view hides it
   task automatic t_scan();
      pulse(SCN, 30);
      chk("scan hold", sys_reset_n, 1'b0);
      wait_rst(1'b1, 40);
      pulse(PIN, 4);
      wait_rst(1'b1, 40);
      legacy <= 1'b1;
      rd(REG_FLAGS, 32'h0000_0002, RESP_OKAY);
      legacy <= 1'b0;
      rd(REG_FLAGS, 32'h0000_0012, RESP_OKAY);
      $display("scan test done");
   endtask : t_scan

   task automatic t_por();
      @(posedge aclk);
      cmd <= POR;
      wait_rst(1'b0, 5);
      rd(REG_FLAGS, 32'h0000_0001, RESP_OKAY);
      cmd <= '0;
      wait_rst(1'b1, 40);
      $display("power-on test done");
   endtask : t_por

   // Second reset during the count must restart it
   task automatic t_long();
      ck_fuses <= 4'h1;
      pulse(PIN, 4);
      repeat (400) @(posedge aclk);
      pulse(PIN, 4);
      repeat (600) @(posedge aclk);
      chk("long delay", sys_reset_n, 1'b0);
      wait_rst(1'b1, 400);
      ck_fuses <= 4'h0;
      $display("delay test done");
   endtask : t_long

   task automatic gap(input logic [31:0] c, input logic f, input logic e);
      wr(REG_CTRL, c, RESP_OKAY);
      bo_fuse <= f;
      repeat (3) @(posedge aclk);
      chk("bandgap_on", bandgap_on, e);
   endtask : gap

   initial
   begin
      {aclk, aresetn, legacy, cmd, ck_fuses, awaddr, wdata, araddr} = '0;
      {awvalid, wvalid, bready, arvalid, rready, failures, check_count} = '0;
      {bo_fuse, wstrb} = 5'h1F;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_boot();
      t_pin();
      t_wdt();
      t_bor();
      t_scan();
      t_por();
      t_long();
      gap(ZERO32, 1'b0, 1'b0);
      gap(32'h0000_0001, 1'b0, 1'b1);
      gap(32'h0000_0002, 1'b0, 1'b1);
      repeat (BG_WAIT) @(posedge aclk);
      rd(REG_CTRL, 32'h0000_0002, RESP_OKAY);
      gap(ZERO32, 1'b1, 1'b1);
      $display("bandgap test done");
      end_of_test();
   end
endmodule : rcf_top_bench
